// ===== design/adc_port_defines.vh
// How it works
// (RULE1) Each result appears on the data outputs 9.5 sample clocks after sampling.
// (RULE2) Data bus is driven only while output enable is low, else released.
// (RULE3) During a read the register select chooses which value is driven.
// (RULE4) Register select zero returns the latest conversion result.
// (RULE5) Control, gain and offset registers can be read back over the bus.
// (RULE6) Bus accesses are honoured only while chip select is low.
// (RULE7) Writes are signalled by a low pulse of the write strobe.
// (RULE8) Select decode: 00 result, 01 gain, 10 offset, 11 control.
// (RULE9) Clip flag follows the data with the same pipeline delay.
// (RULE10) Format bit 0 gives straight binary, 1 gives two's complement.
// (RULE11) Rising write strobe under chip select stores data; result address ignores writes.
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH
`define DATA_W        14
`define SEL_RESULT    2'h0
`define SEL_GAIN      2'h1
`define SEL_OFFSET    2'h2
`define SEL_CTRL      2'h3
`define GAIN_W        3
`define OFFSET_W      8
`define CTRL_LSB      6
`define CTRL_W        8
`define CTRL_FMT_BIT  5
`define CTRL_OFF_BIT  1
`define CTRL_PWD_BIT  7
`define CTRL_REF_BIT  6
`define CTRL_TM_MSB   4
`define CTRL_TM_LSB   2
`define SYNC_HIGH     3'h7
`define PIPE_FULL     9
`define CODE_MSB_FLIP 14'h2000
`define CODE_MAX      14'h3fff
`define CODE_MIN      14'h0000
`define RESET_14      14'h0000
`define RESET_8       8'h00
`define RESET_3       3'h0
`endif

// ===== design/sample_delay_line.v
`timescale 1ns/1ns
`include "adc_port_defines.vh"
// Delays sample code and clip flag by a fixed number of sample clocks
module sample_delay_line
#(
	parameter DEPTH = `PIPE_FULL
)
(
	// Clock and reset
	input  wire                 i_ref_clk,
	input  wire                 i_rst_b,
	// Stream in
	input  wire                 i_adv,
	input  wire [`DATA_W-1:0]   i_code,
	input  wire                 i_clip,
	// Stream out
	output wire [`DATA_W-1:0]   o_code,
	output wire                 o_clip
);
	reg [`DATA_W:0] stage_reg [0:DEPTH-1];
	genvar g;
	// Shift chain, one stage per sample clock
	generate
		for (g = 0; g < DEPTH; g = g + 1)
		begin : stg
			always @(posedge i_ref_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
					stage_reg[g] <= {1'b0, `RESET_14};
				else if (i_adv)
					stage_reg[g] <= (g == 0) ? {i_clip, i_code} : stage_reg[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate
	assign o_code = stage_reg[DEPTH-1][`DATA_W-1:0];
	assign o_clip = stage_reg[DEPTH-1][`DATA_W];
endmodule

// ===== design/adc_parallel_bus_port.v
`timescale 1ns/1ns
`include "adc_port_defines.vh"
// Parallel host port: sample pipeline, configuration registers, three-state bus
module adc_parallel_bus_port
(
	// Clock and reset
	input  wire                 i_ref_clk,
	input  wire                 i_rst_b,
	// Sample clock pin and converter core
	input  wire                 i_sample_clk,
	input  wire [`DATA_W-1:0]   i_raw_code,
	input  wire                 i_over_range,
	// Host bus pins
	input  wire                 i_cs_b,
	input  wire                 i_oe_b,
	input  wire                 i_wr_b,
	input  wire [1:0]           i_reg_sel,
	input  wire [`DATA_W-1:0]   i_data,
	output reg  [`DATA_W-1:0]   o_data,
	output wire                 o_data_oe_b,
	// Status and configuration outputs
	output reg                  o_clip_flag,
	output wire [`GAIN_W-1:0]   o_gain,
	output wire                 o_power_down,
	output wire                 o_ext_ref,
	output wire [2:0]           o_test_mode
);
	// Three-flop synchronisers for pins
	reg [2:0]          clk_sync_reg;
	reg [2:0]          cs_sync_reg;
	reg [2:0]          oe_sync_reg;
	reg [2:0]          wr_sync_reg;
	reg                clk_lvl_reg;
	reg                cs_lvl_reg;
	reg                oe_lvl_reg;
	reg                wr_lvl_reg;
	reg [1:0]          sel_s0_reg;
	reg [1:0]          sel_s1_reg;
	reg [1:0]          sel_s2_reg;
	reg [1:0]          sel_lvl_reg;
	reg [`DATA_W-1:0]  din_s0_reg;
	reg [`DATA_W-1:0]  din_s1_reg;
	reg [`DATA_W-1:0]  din_s2_reg;
	reg [`DATA_W-1:0]  din_lvl_reg;
	reg [`DATA_W-1:0]  held_code_reg;
	reg                held_clip_reg;
	reg [`DATA_W-1:0]  wdata_reg;
	reg [1:0]          wsel_reg;
	reg [`GAIN_W-1:0]  gain_reg;
	reg [`OFFSET_W-1:0] offset_reg;
	reg [`CTRL_W-1:0]  ctrl_reg;
	reg [`DATA_W-1:0]  result_reg;
	reg [`DATA_W-1:0]  rd_next;
	reg [`DATA_W-1:0]  fmt_code;
	wire               rise_clk;
	wire               fall_clk;
	wire               wr_rise;
	wire [`DATA_W-1:0] piped_code;
	wire               piped_clip;
	wire [`DATA_W+1:0] sum_wide;
	wire [`DATA_W-1:0] corr_code;

	// Pin synchronisers; a level changes when second and third flops agree
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			clk_sync_reg <= `RESET_3;
			cs_sync_reg  <= `SYNC_HIGH;
			oe_sync_reg  <= `SYNC_HIGH;
			wr_sync_reg  <= `SYNC_HIGH;
			clk_lvl_reg  <= 1'b0;
			cs_lvl_reg   <= 1'b1;
			oe_lvl_reg   <= 1'b1;
			wr_lvl_reg   <= 1'b1;
		end
		else
		begin
			clk_sync_reg <= {clk_sync_reg[1:0], i_sample_clk};
			cs_sync_reg  <= {cs_sync_reg[1:0], i_cs_b};
			oe_sync_reg  <= {oe_sync_reg[1:0], i_oe_b};
			wr_sync_reg  <= {wr_sync_reg[1:0], i_wr_b};
			if (clk_sync_reg[1] == clk_sync_reg[2])
				clk_lvl_reg <= clk_sync_reg[2];
			if (cs_sync_reg[1] == cs_sync_reg[2])
				cs_lvl_reg <= cs_sync_reg[2];
			if (oe_sync_reg[1] == oe_sync_reg[2])
				oe_lvl_reg <= oe_sync_reg[2];
			if (wr_sync_reg[1] == wr_sync_reg[2])
				wr_lvl_reg <= wr_sync_reg[2];
		end
	end

	// Edge strobes of the filtered levels
	assign rise_clk = (clk_sync_reg[1] == clk_sync_reg[2]) && clk_sync_reg[2] && !clk_lvl_reg;
	assign fall_clk = (clk_sync_reg[1] == clk_sync_reg[2]) && !clk_sync_reg[2] && clk_lvl_reg;
	assign wr_rise  = (wr_sync_reg[1] == wr_sync_reg[2]) && wr_sync_reg[2] && !wr_lvl_reg;

	// Select and data pins: three flops, a word counts once second and third agree
	// Same lag as the strobe filters, so select and data line up with the strobes
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sel_s0_reg  <= `SEL_RESULT;
			sel_s1_reg  <= `SEL_RESULT;
			sel_s2_reg  <= `SEL_RESULT;
			sel_lvl_reg <= `SEL_RESULT;
			din_s0_reg  <= `RESET_14;
			din_s1_reg  <= `RESET_14;
			din_s2_reg  <= `RESET_14;
			din_lvl_reg <= `RESET_14;
		end
		else
		begin
			sel_s0_reg <= i_reg_sel;
			sel_s1_reg <= sel_s0_reg;
			sel_s2_reg <= sel_s1_reg;
			din_s0_reg <= i_data;
			din_s1_reg <= din_s0_reg;
			din_s2_reg <= din_s1_reg;
			if (sel_s1_reg == sel_s2_reg)
				sel_lvl_reg <= sel_s2_reg;
			if (din_s1_reg == din_s2_reg)
				din_lvl_reg <= din_s2_reg;
		end
	end

	// Write data and select follow the pins while strobe is low and chip selected, held after
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wdata_reg <= `RESET_14;
			wsel_reg  <= `SEL_RESULT;
		end
		else if (!wr_lvl_reg && !cs_lvl_reg) // RULE7
		begin
			wdata_reg <= din_lvl_reg;
			wsel_reg  <= sel_lvl_reg;
		end
	end

	// Register update on rising write strobe
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			gain_reg   <= `RESET_3;
			offset_reg <= `RESET_8;
			ctrl_reg   <= `RESET_8;
		end
		else if (wr_rise && !cs_lvl_reg) // RULE11 RULE6
		begin
			case (wsel_reg) // RULE8
				`SEL_GAIN:   gain_reg   <= wdata_reg[`GAIN_W-1:0];
				`SEL_OFFSET: offset_reg <= wdata_reg[`OFFSET_W-1:0];
				`SEL_CTRL:   ctrl_reg   <= wdata_reg[`DATA_W-1:`CTRL_LSB];
				default:     gain_reg   <= gain_reg; // RULE11
			endcase
		end
	end

	// Sample-and-hold at the filtered rising sample clock
	// The chain below then adds nine whole clocks before the final half
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			held_code_reg <= `RESET_14;
			held_clip_reg <= 1'b0;
		end
		else if (rise_clk) // RULE1
		begin
			held_code_reg <= i_raw_code;
			held_clip_reg <= i_over_range; // RULE9
		end
	end

	// Nine whole sample clocks of core delay
	sample_delay_line #(.DEPTH(`PIPE_FULL)) u_delay
	(
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.i_adv     (rise_clk),
		.i_code    (held_code_reg),
		.i_clip    (held_clip_reg),
		.o_code    (piped_code),
		.o_clip    (piped_clip)
	);

	// Offset correction, saturating, unless disabled
	assign sum_wide  = {2'b00, piped_code} + {{(`DATA_W+2-`OFFSET_W){offset_reg[`OFFSET_W-1]}}, offset_reg};
	assign corr_code = ctrl_reg[`CTRL_OFF_BIT] ? piped_code :
		(sum_wide[`DATA_W+1] ? `CODE_MIN : (sum_wide[`DATA_W] ? `CODE_MAX : sum_wide[`DATA_W-1:0]));

	// Output format selection
	always @*
	begin
		if (ctrl_reg[`CTRL_FMT_BIT]) // RULE10
			fmt_code = corr_code ^ `CODE_MSB_FLIP;
		else
			fmt_code = corr_code;
	end

	// Final half cycle: result and clip update on falling sample clock
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			result_reg   <= `RESET_14;
			o_clip_flag  <= 1'b0;
		end
		else if (fall_clk) // RULE1
		begin
			result_reg   <= fmt_code;
			o_clip_flag  <= piped_clip; // RULE9
		end
	end

	// Read mux
	always @*
	begin
		case (sel_lvl_reg) // RULE3 RULE8
			`SEL_RESULT: rd_next = result_reg; // RULE4
			`SEL_GAIN:   rd_next = {{(`DATA_W-`GAIN_W){1'b0}}, gain_reg}; // RULE5
			`SEL_OFFSET: rd_next = {{(`DATA_W-`OFFSET_W){1'b0}}, offset_reg};
			`SEL_CTRL:   rd_next = {ctrl_reg, {`CTRL_LSB{1'b0}}};
			default:     rd_next = `RESET_14;
		endcase
	end

	// Read data register
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_data <= `RESET_14;
		else
			o_data <= rd_next;
	end

	// Bus enable, low means driving
	assign o_data_oe_b = oe_lvl_reg | cs_lvl_reg; // RULE2 RULE6

	// Configuration outputs
	assign o_gain       = gain_reg;
	assign o_power_down = ctrl_reg[`CTRL_PWD_BIT];
	assign o_ext_ref    = ctrl_reg[`CTRL_REF_BIT];
	assign o_test_mode  = ctrl_reg[`CTRL_TM_MSB:`CTRL_TM_LSB];
endmodule

// ===== verif/adc_port_sva.sv
`timescale 1ns/1ns
module adc_port_sva
(
	input wire		i_ref_clk,
	input wire		i_rst_b,
	input wire		i_sample_clk,
	input wire		i_cs_b,
	input wire		i_oe_b,
	input wire		i_wr_b,
	input wire [1:0]	i_reg_sel,
	input wire [13:0]	o_data,
	input wire		o_data_oe_b,
	input wire		o_clip_flag,
	input wire [2:0]	o_gain,
	input wire		o_power_down,
	input wire		o_ext_ref,
	input wire [2:0]	o_test_mode
);
	wire [7:0] cfg = {o_gain, o_power_down, o_ext_ref, o_test_mode};
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// Bus enable and read mux; read data trails the select pins by the filter and one register
	oe_idle_a: assert property (i_oe_b [*6] |-> o_data_oe_b) else $error("oe");
	cs_idle_a: assert property (i_cs_b [*6] |-> o_data_oe_b) else $error("cs");
	drive_a: assert property (!(i_cs_b | i_oe_b) [*8] |-> !o_data_oe_b) else $error("drive");
	gain_rd_a: assert property ((i_reg_sel == 2'h1 && $stable(o_gain)) [*6] |-> o_data[2:0] == o_gain)
		else $error("gain");
	ctrl_rd_a: assert property ((i_reg_sel == 2'h3 && $stable(cfg)) [*6] |->
		{o_data[13:12], o_data[10:8]} == cfg[4:0]) else $error("ctrl");
	// Configuration moves only on a selected write
	wr_idle_a: assert property (i_wr_b [*8] |-> $stable(cfg)) else $error("cfg");
	cs_wr_a: assert property (i_cs_b [*8] |-> $stable(cfg)) else $error("cfg");
	// Sample path moves only with the sample clock
	clip_a: assert property ($stable(i_sample_clk) [*8] |-> $stable(o_clip_flag)) else $error("clip");
	res_a: assert property ((i_reg_sel == 2'h0 && $stable(i_sample_clk)) [*8] |-> $stable(o_data))
		else $error("result");
endmodule
bind adc_parallel_bus_port adc_port_sva u_sva (.*);

// ===== verif/host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model
(
	input wire		i_ref_clk,
	input wire		i_dev_oe_b,
	output reg		o_cs_b,
	output reg		o_oe_b,
	output reg		o_wr_b,
	output reg [1:0]	o_sel,
	output wire [13:0]	o_data,
	output reg		o_take
);
	reg busy;
	reg [13:0] wd;
	reg [13:0] idle_q;
	integer n;
	initial {o_cs_b, o_oe_b, o_wr_b, o_sel, wd, idle_q, o_take, busy} = {3'h7, 32'h0};
	// Released data lines toggle every cycle
	always @(negedge i_ref_clk) idle_q <= ~idle_q;
	assign o_data = busy ? wd : idle_q;
	// Write cycle, c high leaves the device unselected
	task wr(input [1:0] s, input [13:0] d, input c);
		begin
			@(negedge i_ref_clk);
			busy = 1;
			{o_cs_b, o_sel, wd, o_wr_b} = {c, s, d, 1'b0};
			repeat (4) @(negedge i_ref_clk);
			o_wr_b = 1;
			repeat (4) @(negedge i_ref_clk);
			{o_cs_b, busy} = 2'h2;
		end
	endtask
	// Read cycle, strobes o_take once data has settled
	task rd(input [1:0] s);
		begin
			@(negedge i_ref_clk);
			{o_cs_b, o_oe_b, o_sel} = {2'h0, s};
			for (n = 0; n < 20 && i_dev_oe_b !== 1'b0; n = n + 1) @(negedge i_ref_clk);
			repeat (2) @(negedge i_ref_clk);
			o_take = 1;
			@(negedge i_ref_clk);
			{o_take, o_cs_b, o_oe_b} = 3'h3;
			// Stay deselected long enough for the pin filter to see it
			repeat (4) @(negedge i_ref_clk);
		end
	endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb;
	reg		i_ref_clk, i_rst_b, sclk, clp;
	reg [13:0]	code, ctl, hc[$];
	reg [15:0]	r, q[$];
	reg [7:0]	off;
	integer		err_total, checks_done, cyc, p, k;
	wire		cs_b, oe_b, wr_b, doe_b, clip, take;
	wire [1:0]	sel;
	wire [13:0]	hd, dout;
	adc_parallel_bus_port dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sample_clk(sclk), .i_raw_code(code),
		.i_over_range(code[0]), .i_cs_b(cs_b), .i_oe_b(oe_b), .i_wr_b(wr_b), .i_reg_sel(sel), .i_data(hd),
		.o_data(dout), .o_data_oe_b(doe_b), .o_clip_flag(clip), .o_gain(), .o_power_down(), .o_ext_ref(),
		.o_test_mode());
	host_bus_model hm (.i_ref_clk(i_ref_clk), .i_dev_oe_b(doe_b), .o_cs_b(cs_b), .o_oe_b(oe_b), .o_wr_b(wr_b),
		.o_sel(sel), .o_data(hd), .o_take(take));
	function [15:0] nx(input [15:0] x);
		nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Offset with saturation, then format
	function [13:0] xc(input [13:0] c);
		integer s;
		begin
			s = c;
			if (!ctl[7]) s = s + $signed(off);
			if (s < 0) s = 0;
			if (s > 16383) s = 16383;
			xc = s[13:0] ^ {ctl[11], 13'h0};
		end
	endfunction
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp)
			begin
				err_total = err_total + 1;
				$display("[ERR] %0t %h %h", $time, got, exp);
			end
		end
	endtask
	task final_report;
		begin
			if (err_total == 0 && checks_done > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task rd(input [1:0] s, input [13:0] e);
		begin
			q.push_back({1'b0, clp, e});
			hm.rd(s);
		end
	endtask
	// Result checker
	always @(posedge take) cmp({doe_b, clip, dout}, q.pop_front());
	// Clock and hang limit
	initial
	begin
		i_ref_clk = 0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			err_total = err_total + 1;
			final_report;
		end
	end
	// Main sequence
	initial
	begin
		{i_rst_b, sclk, clp, code, ctl, off} = 0;
		{r, err_total, checks_done, cyc} = {16'h0010, 96'h0};
		repeat (6) @(negedge i_ref_clk);
		i_rst_b = 1;
		repeat (6) @(negedge i_ref_clk);
		for (p = 0; p < 4; p = p + 1)
		begin
			r = nx(r);
			off = r[10:3];
			ctl = {r[15], r[11], p[0], r[14:12], p[1], 7'h0};
			hm.wr(2'h1, {11'h0, r[2:0]}, 1'b0);
			hm.wr(2'h2, {6'h0, off}, 1'b0);
			hm.wr(2'h3, ctl, 1'b0);
			hm.wr(2'h1, 14'h3fff, 1'b1);
			hm.wr(2'h0, 14'h3fff, 1'b0);
			rd(2'h1, {11'h0, r[2:0]});
			rd(2'h2, {6'h0, off});
			rd(2'h3, ctl);
			for (k = 0; k < 12; k = k + 1)
			begin
				r = nx(r);
				code = (p == 1) ? {14{r[0]}} : r[13:0];
				hc.push_back(code);
				sclk = 1;
				repeat (8) @(negedge i_ref_clk);
				sclk = 0;
				repeat (8) @(negedge i_ref_clk);
			end
			clp = hc[hc.size() - 10][0];
			rd(2'h0, xc(hc[hc.size() - 10]));
		end
		final_report;
	end
endmodule
